/* File: bench/power_status_register_bank_bench.sv */
// Bench: drives events, reads back through the host model.
// Assumes the checker is bound to the bank.
`timescale 1ns/1ns
module power_status_register_bank_bench;
   import psr_pkg::*;
   logic        clk = 0, resetn = 0, busy = 0, off = 0, pg = 1, unl = 0;
   logic [7:0]  ev [6] = '{default: 8'h00};
   logic [7:0]  cmd_code, r, w, x;
   logic        cmd_write, cmd_read, cmd_rvalid_q, alert_n_q;
   logic [15:0] cmd_wdata, cmd_rdata_q;
   logic [15:0] expq [$];
   int          fail_count = 0, n_compared = 0;
   logic [31:0] seed = 32'h75592e0b;
   logic [7:0]  codes [6] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
   logic [7:0]  msk [6] = '{MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG, MASK_OUTPUT_CURRENT_SUMMARY_FLAG, MASK_INPUT, MASK_TEMP, MASK_CML, MASK_VENDOR};
   logic [7:0]  cmsk [6] = '{MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG, MASK_OUTPUT_CURRENT_SUMMARY_FLAG, MASK_INPUT_CLR, MASK_TEMP, MASK_CML, MASK_VENDOR};
   always #10 clk = ~clk;
   psr_host_model host (.clk(clk), .cmd_code(cmd_code), .cmd_write(cmd_write),
      .cmd_read(cmd_read), .cmd_wdata(cmd_wdata));
   psr_status_bank dut (.clk(clk), .resetn(resetn), .busy_event(busy), .output_off(off),
      .power_good(pg), .unlisted_event(unl), .output_voltage_summary_flag_events(ev[0]), .output_current_summary_flag_events(ev[1]),
      .input_events(ev[2]), .temp_events(ev[3]), .cml_events(ev[4]), .vendor_events(ev[5]),
      .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata),
      .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q), .alert_n_q(alert_n_q));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      expq.push_back(e);
      host.xfer(c, seed[15:0], 1'b0);
   endtask
   task automatic clear_all;
      host.xfer(CODE_CLEAR_ALL, 16'h0000, 1'b1);
   endtask
   // Sampled mid-cycle, well clear of the edge that launches the answer
   always @(negedge clk)
      if (cmd_rvalid_q === 1'b1)
         check("rdata", cmd_rdata_q, expq.size() > 0 ? expq.pop_front() : 16'hxxxx);
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      #1 resetn = 1;
      for (int i = 0; i < 6; i++) rd(codes[i], 16'h0000);
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         r = seed[7:0];
         w = seed[15:8];
         x = r & msk[i];
         ev[i] = r;
         @(posedge clk);
         #1 ev[i] = 8'h00;
         rd(codes[i], {8'h00, x});
         rd(CODE_SUMMARY_WORD, {i == 0 && x != 0, i == 1 && x != 0, i == 2 && x != 0,
            i == 5 && x != 0, 6'h00, i == 0 && x[7], i == 1 && x[7], 1'b0,
            i == 3 && x != 0, i == 4 && x != 0, 1'b0});
         host.xfer(codes[i], {seed[31:24], w}, 1'b1);
         rd(codes[i], {8'h00, x & ~(w & cmsk[i])});
         clear_all();
         rd(codes[i], 16'h0000);
      end
      {busy, unl, off, pg} = 4'b1110;
      @(posedge clk);
      #1 {busy, unl} = 2'b00;
      rd(CODE_SUMMARY_BYTE, 16'h00c1);
      rd(CODE_SUMMARY_WORD, 16'h08c1);
      host.xfer(CODE_SUMMARY_WORD, 16'h0081, 1'b1);
      {off, pg} = 2'b01;
      rd(CODE_SUMMARY_BYTE, 16'h0000);
      ev[1] = 8'h80;
      clear_all();
      rd(CODE_OUTPUT_CURRENT_SUMMARY_FLAG_STATUS, 16'h0080);
      check("alert", {15'h0000, alert_n_q}, 16'h0000);
      ev[1] = 8'h00;
      rd(8'h55, 16'h0000);
      rd(CODE_CML_STATUS, 16'h0080);
      clear_all();
      repeat (3) @(posedge clk);
      #1 check("alert", {15'h0000, alert_n_q}, 16'h0001);
      if (expq.size() != 0) fail_count++;
      print_verdict();
   end
endmodule

/* File: bench/psr_checker.sv */
// Checker of the status bank ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module psr_checker
   import psr_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        busy_event,
   input wire logic        output_off,
   input wire logic        power_good,
   input wire logic        unlisted_event,
   input wire logic [7:0]  output_voltage_summary_flag_events,
   input wire logic [7:0]  output_current_summary_flag_events,
   input wire logic [7:0]  input_events,
   input wire logic [7:0]  temp_events,
   input wire logic [7:0]  cml_events,
   input wire logic [7:0]  vendor_events,
   input wire logic [7:0]  cmd_code,
   input wire logic        cmd_write,
   input wire logic        cmd_read,
   input wire logic [15:0] cmd_wdata,
   input wire logic [15:0] cmd_rdata_q,
   input wire logic        cmd_rvalid_q,
   input wire logic        alert_n_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   AST_RVALID: assert property (cmd_read |=> cmd_rvalid_q)
      else $error("read not answered");
   AST_RVALID_ONE: assert property (!cmd_read |=> !cmd_rvalid_q)
      else $error("answer without read");
   AST_HOLD: assert property (!cmd_read |=> $stable(cmd_rdata_q))
      else $error("read data moved");
   AST_BYTE_HI: assert property (cmd_read && cmd_code != CODE_SUMMARY_WORD
      |=> cmd_rdata_q[15:8] == 8'h00) else $error("byte read high bits");
   AST_SUM: assert property (cmd_read && cmd_code inside {8'h78, 8'h79}
      |=> cmd_rdata_q[6] == $past(output_off) && !cmd_rdata_q[3]) else $error("summary");
   AST_WORD: assert property (cmd_read && cmd_code == CODE_SUMMARY_WORD
      |=> cmd_rdata_q[11:8] == {!$past(power_good), 3'h0}) else $error("word high");
   AST_UNSUP: assert property (cmd_read && cmd_code inside {8'h7a, 8'h7b, 8'h7d}
      |=> (cmd_rdata_q[7:0] & ~(MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG | MASK_OUTPUT_CURRENT_SUMMARY_FLAG | MASK_TEMP)) == 8'h00
         && !(cmd_code == CODE_OUTPUT_VOLTAGE_SUMMARY_FLAG_STATUS && cmd_rdata_q[0])) else $error("unsupported bit");
   AST_ALERT_A: assert property ((busy_event || unlisted_event || input_events[7]
      || |(output_voltage_summary_flag_events & MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG)) |=> ##1 !alert_n_q) else $error("alert missing");
   AST_ALERT_B: assert property (|(output_current_summary_flag_events & MASK_OUTPUT_CURRENT_SUMMARY_FLAG | temp_events & MASK_TEMP
      | cml_events & MASK_CML | vendor_events & MASK_VENDOR) |=> ##1 !alert_n_q)
      else $error("alert missing");
   AST_CLR_ALL: assert property (cmd_write && cmd_code == CODE_CLEAR_ALL && !busy_event
      && !unlisted_event && (output_voltage_summary_flag_events | output_current_summary_flag_events | input_events | temp_events
      | cml_events | vendor_events) == 8'h00 |=> ##1 alert_n_q) else $error("alert kept");
   AST_RESET: assert property (disable iff (1'b0) !resetn
      |=> alert_n_q && !cmd_rvalid_q && cmd_rdata_q == 16'h0000) else $error("reset value");
endmodule
bind psr_status_bank psr_checker chk (.clk(clk), .resetn(resetn), .busy_event(busy_event),
   .output_off(output_off), .power_good(power_good), .unlisted_event(unlisted_event),
   .output_voltage_summary_flag_events(output_voltage_summary_flag_events), .output_current_summary_flag_events(output_current_summary_flag_events), .input_events(input_events),
   .temp_events(temp_events), .cml_events(cml_events), .vendor_events(vendor_events),
   .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_wdata(cmd_wdata),
   .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q), .alert_n_q(alert_n_q));

/* File: bench/psr_host_model.sv */
// Host model: one read or write strobe per call.
// Assumes the bench calls xfer; strobes change 1 ns after an edge.
`timescale 1ns/1ns
module psr_host_model (
   input  wire logic        clk,
   output logic [7:0]       cmd_code,
   output logic             cmd_write,
   output logic             cmd_read,
   output logic [15:0]      cmd_wdata
);
   initial {cmd_code, cmd_write, cmd_read, cmd_wdata} = '0;
   task automatic xfer(input logic [7:0] c, input logic [15:0] d, input logic w);
      @(posedge clk);
      #1;
      cmd_code = c;
      cmd_wdata = d;
      cmd_write = w;
      cmd_read = !w;
      @(posedge clk);
      #1;
      // Idle code and data lines show the inverse so stale values cannot pass; strobes drop to 0
      cmd_code = ~c;
      cmd_wdata = ~d;
      cmd_write = 1'b0;
      cmd_read = 1'b0;
   endtask
endmodule

/* File: hw/psr_pkg.sv */
// Constants for the power status register bank.
// Assumes one channel and a command decoder that hands over command codes.
package psr_pkg;

   // Command codes of clear-all and the status registers
   localparam logic [7:0] CODE_CLEAR_ALL    = 8'h03;
   localparam logic [7:0] CODE_SUMMARY_BYTE = 8'h78;
   localparam logic [7:0] CODE_SUMMARY_WORD = 8'h79;
   localparam logic [7:0] CODE_OUTPUT_VOLTAGE_SUMMARY_FLAG_STATUS  = 8'h7a;
   localparam logic [7:0] CODE_OUTPUT_CURRENT_SUMMARY_FLAG_STATUS  = 8'h7b;
   localparam logic [7:0] CODE_INPUT_STATUS = 8'h7c;
   localparam logic [7:0] CODE_TEMP_STATUS  = 8'h7d;
   localparam logic [7:0] CODE_CML_STATUS   = 8'h7e;
   localparam logic [7:0] CODE_VENDOR_STAT  = 8'h80;

   // Supported bits and write-one clear masks of the bytes
   localparam logic [7:0] MASK_SUMMARY_CLR  = 8'h81;
   localparam logic [7:0] MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG         = 8'hfe;
   localparam logic [7:0] MASK_OUTPUT_CURRENT_SUMMARY_FLAG         = 8'ha0;
   localparam logic [7:0] MASK_INPUT        = 8'ha8;
   localparam logic [7:0] MASK_INPUT_CLR    = 8'h80;
   localparam logic [7:0] MASK_TEMP         = 8'hd0;
   localparam logic [7:0] MASK_CML          = 8'hfb;
   localparam logic [7:0] MASK_VENDOR       = 8'hfb;

   // Field positions in the summary byte and word, and in the status bytes
   localparam int BIT_BUSY        = 7;
   localparam int BIT_OFF         = 6;
   localparam int BIT_OVERVOLT    = 5;
   localparam int BIT_OVERCURR    = 4;
   localparam int BIT_TEMP        = 2;
   localparam int BIT_CML         = 1;
   localparam int BIT_UNLISTED    = 0;
   localparam int BIT_W_OUTPUT_VOLTAGE_SUMMARY_FLAG      = 15;
   localparam int BIT_W_OUTPUT_CURRENT_SUMMARY_FLAG      = 14;
   localparam int BIT_W_INPUT     = 13;
   localparam int BIT_W_VENDOR    = 12;
   localparam int BIT_W_PGOOD_N   = 11;
   localparam int BIT_CML_BADCMD  = 7;
   localparam int BIT_TOP         = 7;

   // Values after reset
   localparam logic [7:0]  RESET_BYTE  = 8'h00;
   localparam logic [15:0] RESET_WORD  = 16'h0000;

endpackage

/* File: hw/psr_status_bank.sv */
// Latching fault and warning status bank with clear-by-one and clear-all.
// Assumes event inputs come from detector logic on clk, held high while
// a condition persists; command strobes come from the serial decoder.
`timescale 1ns/1ns

// Summary of operation
// - Busy fault sets summary bit 7
// - Summary bit 6 while output not powered
// - Bits 5, 4 from OV/OC; bit 3 zero
// - Bit 2 temperature, bit 1 COMM_MEMORY_LOGIC_FLAG
// - Bit 0 for unlisted faults
// - Summary bits 7,0 alert; write-one clears
// - Word low byte equals summary byte
// - Word bits 15,14,13 voltage/current/input
// - Word bit 11 while power not good
// - Bit 12 vendor; bits 10..8 zero
// - Output voltage byte layout, bit 0 zero
// - Voltage bits 7..1 alert, write-one clears
// - Input byte bits 7,5,3; only 7 alerts/clears
// - Temperature bits 7,6,4; others zero
// - COMM_MEMORY_LOGIC_FLAG bits 7,6,5 command/data/PEC
// - COMM_MEMORY_LOGIC_FLAG bits 4,3,1,0; bit 2 zero
// - Vendor byte bits 7..3,1,0 layout
// - Any vendor bit sets word bit 12
// - Current/temp/COMM_MEMORY_LOGIC_FLAG/vendor bits raise alert
// - Write-one clears only those bits
// - Current byte bits 7,5; others zero
// - Clear-all empties every latched bit, releases alert
// - Persisting condition sets again at once
module psr_status_bank
   import psr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        busy_event,
   input  wire logic        output_off,
   input  wire logic        power_good,
   input  wire logic        unlisted_event,
   input  wire logic [7:0]  output_voltage_summary_flag_events,
   input  wire logic [7:0]  output_current_summary_flag_events,
   input  wire logic [7:0]  input_events,
   input  wire logic [7:0]  temp_events,
   input  wire logic [7:0]  cml_events,
   input  wire logic [7:0]  vendor_events,
   input  wire logic [7:0]  cmd_code,
   input  wire logic        cmd_write,
   input  wire logic        cmd_read,
   input  wire logic [15:0] cmd_wdata,
   output logic [15:0]      cmd_rdata_q,
   output logic             cmd_rvalid_q,
   output logic             alert_n_q
);
   import psr_pkg::*;

   logic [7:0]  output_voltage_summary_flag_q;
   logic [7:0]  output_current_summary_flag_q;
   logic [7:0]  input_q;
   logic [7:0]  temp_q;
   logic [7:0]  cml_q;
   logic [7:0]  vendor_q;
   logic        busy_q;
   logic        unlisted_q;
   logic        clear_all;
   logic        known_code;
   logic [7:0]  cml_set;
   logic [7:0]  summary_byte;
   logic [15:0] summary_word;
   logic [15:0] rdata_d;
   logic        alert_d;
   logic [7:0]  sclr;

   // Write-one clear mask for one register
   function automatic logic [7:0] clr_mask(input logic [7:0] code,
                                           input logic [7:0] mask);
      clr_mask = (cmd_write && cmd_code == code) ? (cmd_wdata[7:0] & mask) : 8'h00;
   endfunction

   // Next value: clear-all reloads live events, set beats clear
   function automatic logic [7:0] next_bits(input logic [7:0] cur,
                                            input logic [7:0] evt,
                                            input logic [7:0] clr,
                                            input logic [7:0] mask);
      if (clear_all)
         next_bits = evt & mask;
      else
         next_bits = ((cur & ~clr) | evt) & mask;
   endfunction

   assign clear_all = cmd_write && cmd_code == CODE_CLEAR_ALL;

   always_comb
   begin
      case (cmd_code)
         CODE_CLEAR_ALL, CODE_SUMMARY_BYTE, CODE_SUMMARY_WORD, CODE_OUTPUT_VOLTAGE_SUMMARY_FLAG_STATUS,
         CODE_OUTPUT_CURRENT_SUMMARY_FLAG_STATUS, CODE_INPUT_STATUS, CODE_TEMP_STATUS, CODE_CML_STATUS,
         CODE_VENDOR_STAT: known_code = 1'b1;
         default:          known_code = 1'b0;
      endcase
   end

   // Unknown codes are reported as a bad command
   always_comb
   begin
      cml_set = cml_events;
      cml_set[BIT_CML_BADCMD] = cml_events[BIT_CML_BADCMD]
                                | ((cmd_write | cmd_read) & ~known_code);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         output_voltage_summary_flag_q <= RESET_BYTE;
      else
         output_voltage_summary_flag_q <= next_bits(output_voltage_summary_flag_q, output_voltage_summary_flag_events,
                             clr_mask(CODE_OUTPUT_VOLTAGE_SUMMARY_FLAG_STATUS, MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG), MASK_OUTPUT_VOLTAGE_SUMMARY_FLAG);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         output_current_summary_flag_q <= RESET_BYTE;
      else
         output_current_summary_flag_q <= next_bits(output_current_summary_flag_q, output_current_summary_flag_events,
                             clr_mask(CODE_OUTPUT_CURRENT_SUMMARY_FLAG_STATUS, MASK_OUTPUT_CURRENT_SUMMARY_FLAG), MASK_OUTPUT_CURRENT_SUMMARY_FLAG);
   end

   // Only the overvoltage bit clears by write; the rest wait for clear-all
   always_ff @(posedge clk)
   begin
      if (!resetn)
         input_q <= RESET_BYTE;
      else
         input_q <= next_bits(input_q, input_events,
                              clr_mask(CODE_INPUT_STATUS, MASK_INPUT_CLR),
                              MASK_INPUT);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         temp_q <= RESET_BYTE;
      else
         temp_q <= next_bits(temp_q, temp_events,
                             clr_mask(CODE_TEMP_STATUS, MASK_TEMP), MASK_TEMP);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         cml_q <= RESET_BYTE;
      else
         cml_q <= next_bits(cml_q, cml_set,
                            clr_mask(CODE_CML_STATUS, MASK_CML), MASK_CML);
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
         vendor_q <= RESET_BYTE;
      else
         vendor_q <= next_bits(vendor_q, vendor_events,
                               clr_mask(CODE_VENDOR_STAT, MASK_VENDOR), MASK_VENDOR);
   end

   // Summary byte and word low byte share one clear path
   assign sclr = clr_mask(CODE_SUMMARY_BYTE, MASK_SUMMARY_CLR)
                 | clr_mask(CODE_SUMMARY_WORD, MASK_SUMMARY_CLR);

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         busy_q     <= 1'b0;
         unlisted_q <= 1'b0;
      end
      else if (clear_all)
      begin
         busy_q     <= busy_event;
         unlisted_q <= unlisted_event;
      end
      else
      begin
         busy_q     <= (busy_q & ~sclr[BIT_BUSY]) | busy_event;
         unlisted_q <= (unlisted_q & ~sclr[BIT_UNLISTED]) | unlisted_event;
      end
   end

   // Off and power-good follow live state, not latched
   always_comb
   begin
      summary_byte = RESET_BYTE;
      summary_byte[BIT_BUSY]     = busy_q;
      summary_byte[BIT_OFF]      = output_off;
      summary_byte[BIT_OVERVOLT] = output_voltage_summary_flag_q[BIT_TOP];
      summary_byte[BIT_OVERCURR] = output_current_summary_flag_q[BIT_TOP];
      summary_byte[BIT_TEMP]     = |temp_q;
      summary_byte[BIT_CML]      = |cml_q;
      summary_byte[BIT_UNLISTED] = unlisted_q;
      summary_word = {8'h00, summary_byte};
      summary_word[BIT_W_OUTPUT_VOLTAGE_SUMMARY_FLAG]    = |output_voltage_summary_flag_q;
      summary_word[BIT_W_OUTPUT_CURRENT_SUMMARY_FLAG]    = |output_current_summary_flag_q;
      summary_word[BIT_W_INPUT]   = |input_q;
      summary_word[BIT_W_VENDOR]  = |vendor_q;
      summary_word[BIT_W_PGOOD_N] = ~power_good;
   end

   always_comb
   begin
      case (cmd_code)
         CODE_SUMMARY_BYTE: rdata_d = {8'h00, summary_byte};
         CODE_SUMMARY_WORD: rdata_d = summary_word;
         CODE_OUTPUT_VOLTAGE_SUMMARY_FLAG_STATUS:  rdata_d = {8'h00, output_voltage_summary_flag_q};
         CODE_OUTPUT_CURRENT_SUMMARY_FLAG_STATUS:  rdata_d = {8'h00, output_current_summary_flag_q};
         CODE_INPUT_STATUS: rdata_d = {8'h00, input_q};
         CODE_TEMP_STATUS:  rdata_d = {8'h00, temp_q};
         CODE_CML_STATUS:   rdata_d = {8'h00, cml_q};
         CODE_VENDOR_STAT:  rdata_d = {8'h00, vendor_q};
         default:           rdata_d = RESET_WORD;
      endcase
   end

   // Read data is held until the next read
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         cmd_rdata_q  <= RESET_WORD;
         cmd_rvalid_q <= 1'b0;
      end
      else
      begin
         cmd_rvalid_q <= cmd_read;
         if (cmd_read)
            cmd_rdata_q <= rdata_d;
      end
   end

   // Input byte: only the overvoltage bit may pull the alert
   assign alert_d = busy_q | unlisted_q | (|output_voltage_summary_flag_q) | input_q[BIT_TOP]
                    | (|output_current_summary_flag_q) | (|temp_q) | (|cml_q) | (|vendor_q);

   // One cycle behind the status bits; released after clear-all
   always_ff @(posedge clk)
   begin
      if (!resetn)
         alert_n_q <= 1'b1;
      else
         alert_n_q <= ~alert_d;
   end

endmodule
